// [logic/sxp_lane_ctrl.sv]
/*
  Lane control register bank: crossbar, buffer flags, sync-request
  pulse setup and the per-lane PRBS test with its readback.
  Assumes the serial control port has been decoded into a byte-wide
  register port on mclk, and lane buffers and deframer run on mclk.
  The serial lane inputs come from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module sxp_lane_ctrl import sxp_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [LANE_NUM-1:0] serial_lane_input,
  output logic [LANE_NUM-1:0] logical_lane_data,
  input wire logic [LANE_NUM-1:0] fifo_full_in,
  input wire logic [LANE_NUM-1:0] fifo_empty_in,
  input wire logic [LANE_NUM-1:0] disparity_err,
  input wire logic [LANE_NUM-1:0] not_in_table_err,
  input wire logic [LANE_NUM-1:0] unexp_ctrl_err,
  input wire logic multiframe_end,
  output logic sync_request_out_link0_n,
  output logic sync_request_out_link1_n,
  output logic serdes_sync_clk_sel
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [LANE_NUM-1:0] lane_meta_ff;
  logic [LANE_NUM-1:0] lane_sync_ff;
  logic [LANE_NUM-1:0] logical_ff;
  logic [MAP_USED_W-1:0] map01_ff;
  logic [MAP_USED_W-1:0] map23_ff;
  logic [MAP_USED_W-1:0] map45_ff;
  logic [MAP_USED_W-1:0] map67_ff;
  logic [LANE_NUM-1:0] full_ff;
  logic [LANE_NUM-1:0] empty_ff;
  logic [7:0] sync_cfg_ff;
  logic port_sync_ff;
  logic [LANE_NUM-1:0] lane_en_ff;
  logic [CTRL_USED_W-1:0] ctrl_ff;
  logic [7:0] thr0_ff;
  logic [7:0] thr1_ff;
  logic [7:0] thr2_ff;
  logic [7:0] rdata_ff;
  logic sync_n;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire hit_map01 = (reg_addr == OFS_MAP01);
  wire hit_map23 = (reg_addr == OFS_MAP23);
  wire hit_map45 = (reg_addr == OFS_MAP45);
  wire hit_map67 = (reg_addr == OFS_MAP67);
  wire hit_full = (reg_addr == OFS_FULL);
  wire hit_empty = (reg_addr == OFS_EMPTY);
  wire hit_sync_cfg = (reg_addr == OFS_SYNC_CFG);
  wire hit_port_sync = (reg_addr == OFS_PORT_SYNC);
  wire hit_lane_en = (reg_addr == OFS_LANE_EN);
  wire hit_ctrl = (reg_addr == OFS_TEST_CTRL);
  wire hit_thr0 = (reg_addr == OFS_THR0);
  wire hit_thr1 = (reg_addr == OFS_THR1);
  wire hit_thr2 = (reg_addr == OFS_THR2);
  wire hit_cnt0 = (reg_addr == OFS_CNT0);
  wire hit_cnt1 = (reg_addr == OFS_CNT1);
  wire hit_cnt2 = (reg_addr == OFS_CNT2);
  wire hit_pass = (reg_addr == OFS_PASS);

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  wire [1:0] sync_error_pulse_len = sync_cfg_ff[SYNC_DUR_LSB +: 2];
  wire [2:0] error_count_lane_select = ctrl_ff[CTRL_SEL_LSB +: 3];
  wire [1:0] prbs_pattern_select = ctrl_ff[CTRL_PAT_LSB +: 2];
  wire prbs_run = ctrl_ff[CTRL_RUN_BIT];
  wire prbs_clear = ctrl_ff[CTRL_CLR_BIT];
  wire [CNT_W-1:0] prbs_limit = {thr2_ff, thr1_ff, thr0_ff};
  wire link_err = |(disparity_err | not_in_table_err | unexp_ctrl_err);

  // shared map bytes, indexed by logical lane pair
  wire [MAP_USED_W-1:0] map_pair [LANE_NUM/2];
  assign map_pair[0] = map01_ff;
  assign map_pair[1] = map23_ff;
  assign map_pair[2] = map45_ff;
  assign map_pair[3] = map67_ff;

  // ---------------------------------------------------------------
  // lane crossbar and per-lane PRBS checkers
  // ---------------------------------------------------------------
  wire [MAP_SRC_W-1:0] lane_src [LANE_NUM];
  wire [CNT_W-1:0] lane_cnt [LANE_NUM];
  wire [LANE_NUM-1:0] prbs_lane_pass_vec;
  wire [LANE_NUM-1:0] nxt_logical;

  genvar g;
  generate
    for (g = 0; g < LANE_NUM; g++) begin : g_lane
      // odd lanes use the upper field of the pair byte
      assign lane_src[g] = (g % 2 == 1) ?
        map_pair[g/2][MAP_ODD_LSB +: MAP_SRC_W] :
        map_pair[g/2][MAP_EVEN_LSB +: MAP_SRC_W];
      assign nxt_logical[g] = lane_sync_ff[lane_src[g]];

      sxp_prbs_lane u_prbs (
        .mclk(mclk),
        .rst_n(rst_n),
        .rx_bit(lane_sync_ff[g]),
        .lane_on(lane_en_ff[g]),
        .run(prbs_run),
        .clear(prbs_clear),
        .pattern(prbs_pattern_select),
        .threshold(prbs_limit),
        .err_count(lane_cnt[g]),
        .pass(prbs_lane_pass_vec[g])
      );
    end
  endgenerate

  // count of the lane picked for readback
  wire [CNT_W-1:0] sel_cnt = lane_cnt[error_count_lane_select];

  // ---------------------------------------------------------------
  // sync-request pulse
  // ---------------------------------------------------------------
  // one pulse drives both link outputs; they never differ
  sxp_sync_pulse u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .link_err(link_err),
    .mf_end(multiframe_end),
    .dur_sel(sync_error_pulse_len),
    .sync_n(sync_n)
  );

  // ---------------------------------------------------------------
  // read data selection; unmapped offsets read as zero
  // ---------------------------------------------------------------
  wire [7:0] rd_mux =
    ({8{hit_map01}} & {2'b00, map01_ff}) |
    ({8{hit_map23}} & {2'b00, map23_ff}) |
    ({8{hit_map45}} & {2'b00, map45_ff}) |
    ({8{hit_map67}} & {2'b00, map67_ff}) |
    ({8{hit_full}} & full_ff) |
    ({8{hit_empty}} & empty_ff) |
    ({8{hit_sync_cfg}} & sync_cfg_ff) |
    ({8{hit_port_sync}} & {7'h00, port_sync_ff}) |
    ({8{hit_lane_en}} & lane_en_ff) |
    ({8{hit_ctrl}} & {1'b0, ctrl_ff}) |
    ({8{hit_thr0}} & thr0_ff) |
    ({8{hit_thr1}} & thr1_ff) |
    ({8{hit_thr2}} & thr2_ff) |
    ({8{hit_cnt0}} & sel_cnt[7:0]) |
    ({8{hit_cnt1}} & sel_cnt[15:8]) |
    ({8{hit_cnt2}} & sel_cnt[23:16]) |
    ({8{hit_pass}} & prbs_lane_pass_vec);

  // ---------------------------------------------------------------
  // pin synchroniser and crossbar output
  // ---------------------------------------------------------------
  // lane pins are asynchronous to mclk; second stage alone feeds logic
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lane_meta_ff <= RST_ZERO;
      lane_sync_ff <= RST_ZERO;
      logical_ff <= RST_ZERO;
    end else begin
      lane_meta_ff <= serial_lane_input;
      lane_sync_ff <= lane_meta_ff;
      logical_ff <= nxt_logical;
    end
  end

  // ---------------------------------------------------------------
  // buffer flags, sampled every cycle
  // ---------------------------------------------------------------
  // no write path exists, so software cannot disturb the flags
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      full_ff <= RST_ZERO;
      empty_ff <= RST_ZERO;
    end else begin
      full_ff <= fifo_full_in;
      empty_ff <= fifo_empty_in;
    end
  end

  // ---------------------------------------------------------------
  // crossbar map registers
  // ---------------------------------------------------------------
  // reserved bits [7:6] are not stored and read back as zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      map01_ff <= RST_MAP01[MAP_USED_W-1:0];
      map23_ff <= RST_MAP23[MAP_USED_W-1:0];
      map45_ff <= RST_MAP45[MAP_USED_W-1:0];
      map67_ff <= RST_MAP67[MAP_USED_W-1:0];
    end else begin
      if (reg_wr && hit_map01) map01_ff <= reg_wdata[MAP_USED_W-1:0];
      if (reg_wr && hit_map23) map23_ff <= reg_wdata[MAP_USED_W-1:0];
      if (reg_wr && hit_map45) map45_ff <= reg_wdata[MAP_USED_W-1:0];
      if (reg_wr && hit_map67) map67_ff <= reg_wdata[MAP_USED_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // sync and port control registers
  // ---------------------------------------------------------------
  // the sync byte keeps its reserved bits as plain storage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_cfg_ff <= RST_ZERO;
      port_sync_ff <= 1'b0;
    end else begin
      if (reg_wr && hit_sync_cfg) sync_cfg_ff <= reg_wdata;
      if (reg_wr && hit_port_sync) port_sync_ff <= reg_wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // PRBS test registers
  // ---------------------------------------------------------------
  // clear is a level: it holds the checkers until software writes 0
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lane_en_ff <= RST_ZERO;
      ctrl_ff <= RST_ZERO[CTRL_USED_W-1:0];
    end else begin
      if (reg_wr && hit_lane_en) lane_en_ff <= reg_wdata;
      if (reg_wr && hit_ctrl) begin
        ctrl_ff <= reg_wdata[CTRL_USED_W-1:0];
      end
    end
  end

  // threshold bytes, taken one at a time without shadowing
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      thr0_ff <= RST_ZERO;
      thr1_ff <= RST_ZERO;
      thr2_ff <= RST_ZERO;
    end else begin
      if (reg_wr && hit_thr0) thr0_ff <= reg_wdata;
      if (reg_wr && hit_thr1) thr1_ff <= reg_wdata;
      if (reg_wr && hit_thr2) thr2_ff <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // read data register
  // ---------------------------------------------------------------
  // count bytes are not snapshotted, so a running test can tear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_ff <= RST_ZERO;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign logical_lane_data = logical_ff;
  assign sync_request_out_link0_n = sync_n;
  assign sync_request_out_link1_n = sync_n;
  assign serdes_sync_clk_sel = port_sync_ff;

endmodule // sxp_lane_ctrl

`default_nettype wire

// [common/sxp_pkg.sv]
/*
  Shared constants for the lane crossbar, buffer flags, sync-request
  pulse and per-lane PRBS checker register bank.
  Assumes byte-wide registers on a 12-bit register address behind the
  serial control port, and one lane-clock domain (mclk).
*/
// How it works
// - each logical lane takes data from the physical lane named by a 3-bit field, odd lanes in bits [5:3] and even lanes in bits [2:0] of a shared byte.
// - after reset the crossbar maps logical lane n straight to physical lane n.
// - an eight-bit read-only vector shows bit x high while the buffer of logical lane x is full.
// - a second eight-bit read-only vector shows bit x high while the buffer of logical lane x is empty.
// - a sync error fires at the end of every multiframe that saw a disparity, not-in-table or unexpected control character error.
// - a sync error drives both sync-request outputs low for a time picked by a 2-bit field: half, one or two lane-clock cycles.
// - the PRBS checker of lane x runs only while bit x of the lane enable byte is set.
// - a 2-bit selector picks PRBS7, PRBS15 or PRBS31, and code 3 checks nothing.
// - the run bit lets the PRBS test run while 1 and holds it stopped while 0.
// - while the clear bit is 1 the test state machine and all error counters sit in their initial state.
// - a 24-bit error threshold is written as three bytes holding bits [7:0], [15:8] and [23:16].
// - the 24-bit error count of the selected lane reads back over three bytes.
// - a 3-bit lane selector picks the lane whose count is shown.
// - a per-lane pass vector reads back, one bit per lane, resetting to all ones.
// - the third count byte shows bits [23:16] of the selected count.

package sxp_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int LANE_NUM = 8;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 12;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_MAP01 = 12'h308;
  localparam logic [11:0] OFS_MAP23 = 12'h309;
  localparam logic [11:0] OFS_MAP45 = 12'h30A;
  localparam logic [11:0] OFS_MAP67 = 12'h30B;
  localparam logic [11:0] OFS_FULL = 12'h30C;
  localparam logic [11:0] OFS_EMPTY = 12'h30D;
  localparam logic [11:0] OFS_SYNC_CFG = 12'h312;
  localparam logic [11:0] OFS_PORT_SYNC = 12'h314;
  localparam logic [11:0] OFS_LANE_EN = 12'h315;
  localparam logic [11:0] OFS_TEST_CTRL = 12'h316;
  localparam logic [11:0] OFS_THR0 = 12'h317;
  localparam logic [11:0] OFS_THR1 = 12'h318;
  localparam logic [11:0] OFS_THR2 = 12'h319;
  localparam logic [11:0] OFS_CNT0 = 12'h31A;
  localparam logic [11:0] OFS_CNT1 = 12'h31B;
  localparam logic [11:0] OFS_CNT2 = 12'h31C;
  localparam logic [11:0] OFS_PASS = 12'h31D;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MAP_SRC_W = 3;
  localparam int MAP_EVEN_LSB = 0;
  localparam int MAP_ODD_LSB = 3;
  localparam int MAP_USED_W = 6;
  localparam int SYNC_DUR_LSB = 4;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_PAT_LSB = 2;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_USED_W = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MAP01 = 8'h08;
  localparam logic [7:0] RST_MAP23 = 8'h1A;
  localparam logic [7:0] RST_MAP45 = 8'h2C;
  localparam logic [7:0] RST_MAP67 = 8'h3E;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PASS = 8'hFF;

  // ---------------------------------------------------------------
  // pattern codes and checker states
  // ---------------------------------------------------------------
  localparam logic [1:0] PAT_PRBS7 = 2'h0;
  localparam logic [1:0] PAT_PRBS15 = 2'h1;
  localparam logic [1:0] PAT_PRBS31 = 2'h2;
  localparam logic [4:0] HIST_FILL = 5'h1E;

  typedef enum logic [2:0] {
    SXP_IDLE = 3'b001,
    SXP_FILL = 3'b010,
    SXP_CHECK = 3'b100
  } sxp_state_type;

  // ---------------------------------------------------------------
  // sync-request pulse timing; mclk runs at twice the lane clock
  // ---------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 100;
  localparam int SYNC_DUR0_NS = 100;
  localparam int SYNC_DUR1_NS = 200;
  localparam int SYNC_DUR2_NS = 400;
  localparam logic [2:0] SYNC_CYC0 = 3'(SYNC_DUR0_NS / MCLK_PERIOD_NS);
  localparam logic [2:0] SYNC_CYC1 = 3'(SYNC_DUR1_NS / MCLK_PERIOD_NS);
  localparam logic [2:0] SYNC_CYC2 = 3'(SYNC_DUR2_NS / MCLK_PERIOD_NS);

endpackage

// [logic/sxp_prbs_lane.sv]
/*
  One physical lane's PRBS bit-error checker with a saturating error
  counter and a sticky pass flag.
  Assumes one received bit per mclk on rx_bit, already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none

module sxp_prbs_lane import sxp_pkg::*; #(
  parameter int HIST_W = 31
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rx_bit,
  input wire logic lane_on,
  input wire logic run,
  input wire logic clear,
  input wire logic [1:0] pattern,
  input wire logic [CNT_W-1:0] threshold,
  output logic [CNT_W-1:0] err_count,
  output logic pass
);

  sxp_state_type state_ff;
  sxp_state_type nxt_state;
  logic [HIST_W-1:0] hist_ff;
  logic [4:0] fill_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic pass_ff;

  // ---------------------------------------------------------------
  // expected bit from the received history (self-synchronising)
  // ---------------------------------------------------------------
  wire active = lane_on && run;
  wire exp7 = hist_ff[6] ^ hist_ff[5];
  wire exp15 = hist_ff[14] ^ hist_ff[13];
  wire exp31 = hist_ff[30] ^ hist_ff[27];
  wire pat_ok = (pattern != 2'h3);
  wire expected = (pattern == PAT_PRBS7) ? exp7 :
                  (pattern == PAT_PRBS15) ? exp15 : exp31;
  wire bit_err = active && pat_ok && (state_ff == SXP_CHECK) &&
                 (rx_bit != expected);
  wire cnt_max = &cnt_ff;
  // saturate so a long soak never wraps back under the threshold
  wire [CNT_W-1:0] nxt_cnt = (bit_err && !cnt_max) ?
                             cnt_ff + 24'h000001 : cnt_ff;
  wire hit = (nxt_cnt != 24'h000000) && (nxt_cnt >= threshold);

  // state walk: idle until enabled, fill history, then check
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SXP_IDLE: if (active) nxt_state = SXP_FILL;
      SXP_FILL: if (!active) nxt_state = SXP_IDLE;
                else if (fill_ff == HIST_FILL) nxt_state = SXP_CHECK;
      SXP_CHECK: if (!active) nxt_state = SXP_IDLE;
      default: nxt_state = SXP_IDLE;
    endcase
  end

  // clear holds everything at its start value, like reset
  always_ff @(posedge mclk) begin
    if (!rst_n || clear) begin
      state_ff <= SXP_IDLE;
      hist_ff <= '0;
      fill_ff <= 5'h00;
      cnt_ff <= 24'h000000;
      pass_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (active) hist_ff <= {hist_ff[HIST_W-2:0], rx_bit};
      fill_ff <= (state_ff == SXP_FILL) ? fill_ff + 5'h01 : 5'h00;
      cnt_ff <= nxt_cnt;
      if (hit) pass_ff <= 1'b0;
    end
  end

  assign err_count = cnt_ff;
  assign pass = pass_ff;

endmodule // sxp_prbs_lane

`default_nettype wire

// [logic/sxp_sync_pulse.sv]
/*
  Sync-request pulse generator: collects link errors over a multiframe
  and drives an active-low request pulse at its end.
  Assumes error and multiframe-end strobes from deframer logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module sxp_sync_pulse import sxp_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_err,
  input wire logic mf_end,
  input wire logic [1:0] dur_sel,
  output logic sync_n
);

  logic err_seen_ff;
  logic [2:0] left_ff;
  logic sync_n_ff;

  // an error in the closing cycle still belongs to that multiframe
  wire fire = mf_end && (err_seen_ff || link_err);
  wire [2:0] len = (dur_sel == 2'h0) ? SYNC_CYC0 :
                   (dur_sel == 2'h1) ? SYNC_CYC1 : SYNC_CYC2;
  wire [2:0] nxt_left = fire ? len :
                        (left_ff != 3'h0) ? left_ff - 3'h1 : 3'h0;

  // error latch, pulse length counter and output flop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      err_seen_ff <= 1'b0;
      left_ff <= 3'h0;
      sync_n_ff <= 1'b1;
    end else begin
      err_seen_ff <= mf_end ? 1'b0 : (err_seen_ff || link_err);
      left_ff <= nxt_left;
      sync_n_ff <= (nxt_left == 3'h0);
    end
  end

  assign sync_n = sync_n_ff;

endmodule // sxp_sync_pulse

`default_nettype wire

// [verif/sxp_lane_ctrl_sva.sv]
/* port checker for sxp_lane_ctrl.
   assumes one mclk domain and a synchronous active-low rst_n. */
`timescale 1ns/1ps
`default_nettype none
module sxp_lane_ctrl_sva import sxp_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic [LANE_NUM-1:0] fifo_full_in,
  input wire logic [LANE_NUM-1:0] fifo_empty_in,
  input wire logic [LANE_NUM-1:0] disparity_err,
  input wire logic multiframe_end,
  input wire logic sync_request_out_link0_n,
  input wire logic sync_request_out_link1_n
);
  // ------
  // properties
  // ------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_sync_pair_equal: assert property (
    sync_request_out_link0_n == sync_request_out_link1_n)
    else $error("sync outputs differ");
  a_sync_after_end: assert property ($fell(sync_request_out_link0_n) |->
    $past(multiframe_end) || $past(multiframe_end, 2))
    else $error("sync fell with no multiframe end");
  a_sync_err_fires: assert property (
    multiframe_end && (|disparity_err) |-> ##[1:2] !sync_request_out_link0_n)
    else $error("sync error not raised");
  // restarts may chain pulses, so the cap leaves one spare cycle
  a_sync_len_cap: assert property (
    not ((!sync_request_out_link0_n && !multiframe_end) [*6]))
    else $error("sync pulse too long");
  // the flag register lags the live input by one edge
  a_full_readback: assert property (
    reg_rd && $past(rst_n) && reg_addr == OFS_FULL |=>
    reg_rdata == $past(fifo_full_in, 2)) else $error("full flags wrong");
  a_empty_readback: assert property (
    reg_rd && $past(rst_n) && reg_addr == OFS_EMPTY |=>
    reg_rdata == $past(fifo_empty_in, 2)) else $error("empty flags wrong");
  a_map_rsvd_zero: assert property (
    reg_rd && reg_addr >= OFS_MAP01 && reg_addr <= OFS_MAP67 |=>
    reg_rdata[7:6] == 2'h0) else $error("map reserved bits set");
  a_ctrl_rsvd_zero: assert property (
    reg_rd && reg_addr == OFS_TEST_CTRL |=> !reg_rdata[7])
    else $error("control bit 7 set");
  c_sync_pulse: cover property ($fell(sync_request_out_link0_n));
  c_pass_read: cover property (reg_rd && reg_addr == OFS_PASS);
  c_ctrl_write: cover property (reg_wr && reg_addr == OFS_TEST_CTRL);
endmodule // sxp_lane_ctrl_sva
bind sxp_lane_ctrl sxp_lane_ctrl_sva u_sva (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .fifo_full_in(fifo_full_in),
  .fifo_empty_in(fifo_empty_in), .disparity_err(disparity_err),
  .multiframe_end(multiframe_end),
  .sync_request_out_link0_n(sync_request_out_link0_n),
  .sync_request_out_link1_n(sync_request_out_link1_n));
`default_nettype wire

// [verif/sxp_tx_model.sv]
/* transmitter stand-in: one PRBS stream, lane x shows it x bits late.
   assumes the bench flips lanes for one cycle through flip_mask. */
`timescale 1ns/1ps
`default_nettype none
module sxp_tx_model import sxp_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] pattern,
  input wire logic [LANE_NUM-1:0] flip_mask,
  output logic [LANE_NUM-1:0] serial_lane_input
);
  logic [30:0] gen_ff;
  logic nxt_bit;
  // ------
  // generator
  // ------
  // code 3 falls back to the short pattern
  always_comb begin
    case (pattern)
      PAT_PRBS15: nxt_bit = gen_ff[14] ^ gen_ff[13];
      PAT_PRBS31: nxt_bit = gen_ff[30] ^ gen_ff[27];
      default: nxt_bit = gen_ff[6] ^ gen_ff[5];
    endcase
  end
  // lanes move after the falling edge, away from the sampling edge
  always @(negedge mclk) begin
    if (!rst_n) begin
      gen_ff <= 31'h7FFFFFFF;
    end else begin
      gen_ff <= {gen_ff[29:0], nxt_bit};
    end
  end
  // staggered lanes keep the crossbar check meaningful
  assign serial_lane_input = gen_ff[7:0] ^ flip_mask;
endmodule // sxp_tx_model
`default_nettype wire

// [verif/sxp_lane_ctrl_tb.sv]
/* self-checking bench for sxp_lane_ctrl through its register port.
   assumes a 10 MHz mclk and the transmitter model on the lanes. */
`timescale 1ns/1ps
`default_nettype none
module sxp_lane_ctrl_tb import sxp_pkg::*;;
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic mf_end = 1'b0, s0, s1, ssel;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, rdata, ldata, lanes, h1, h2, h3;
  logic [7:0] full_in = 8'h00, empty_in = 8'h00, flip = 8'h00;
  logic [23:0] err_v = 24'h000000;
  logic [1:0] pat = 2'h0;
  logic [7:0] rv [4] = '{RST_MAP01, RST_MAP23, RST_MAP45, RST_MAP67};
  logic [7:0] sl [4] = '{8'(SYNC_CYC0), 8'(SYNC_CYC1), 8'(SYNC_CYC2),
    8'(SYNC_CYC2)};
  int mismatches = 0, check_count = 0, cyc = 0;
  always #50 mclk = ~mclk;
  sxp_lane_ctrl uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .serial_lane_input(lanes),
    .logical_lane_data(ldata), .fifo_full_in(full_in),
    .fifo_empty_in(empty_in), .disparity_err(err_v[7:0]),
    .not_in_table_err(err_v[15:8]), .unexp_ctrl_err(err_v[23:16]),
    .multiframe_end(mf_end), .sync_request_out_link0_n(s0),
    .sync_request_out_link1_n(s1), .serdes_sync_clk_sel(ssel));
  sxp_tx_model u_tx (.mclk(mclk), .rst_n(rst_n), .pattern(pat),
    .flip_mask(flip), .serial_lane_input(lanes));
  // ------
  // tasks
  // ------
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    check(n, rdata, e);
  endtask
  // one multiframe, optionally with an error on lane 3 of kind k
  task automatic pulse(input int d, input int k, input logic e, input logic [7:0] x);
    logic [7:0] n;
    n = 8'h00;
    wr(OFS_SYNC_CFG, 8'(d << SYNC_DUR_LSB));
    err_v = e ? 24'h000001 << (k * 8 + 3) : 24'h000000;
    @(negedge mclk);
    err_v = 24'h000000;
    repeat (4) @(negedge mclk);
    mf_end = 1'b1;
    @(negedge mclk);
    mf_end = 1'b0;
    repeat (8) begin
      if (s0 === 1'b0) n++;
      check("sync_pair", {7'h00, s1}, {7'h00, s0});
      @(negedge mclk);
    end
    check("sync_len", n, x);
  endtask
  task automatic flip_run(input logic [7:0] m);
    repeat (40) @(negedge mclk);
    flip = m;
    @(negedge mclk);
    flip = 8'h00;
    repeat (40) @(negedge mclk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // lane history sampled on the design's own edge
  always @(posedge mclk) begin
    h1 <= lanes;
    h2 <= h1;
    h3 <= h2;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ------
  // sequence
  // ------
  initial begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    foreach (rv[i]) rchk("map_rst", OFS_MAP01 + 12'(i), rv[i]);
    rchk("pass_rst", OFS_PASS, RST_PASS);
    rchk("unmapped", 12'h300, 8'h00);
    check("xbar_rst", ldata, h3);
    wr(OFS_MAP01, 8'hC7); // reserved bits written high must not stick
    repeat (6) begin
      @(negedge mclk);
      check("xbar", ldata, {h3[7:2], h3[0], h3[7]});
    end
    rchk("map01", OFS_MAP01, 8'h07);
    full_in = 8'hA5;
    empty_in = 8'h3C;
    wr(OFS_FULL, 8'hFF);
    rchk("full", OFS_FULL, 8'hA5);
    rchk("empty", OFS_EMPTY, 8'h3C);
    full_in = 8'h5A;
    rchk("full_live", OFS_FULL, 8'h5A);
    for (int d = 0; d < 4; d++) pulse(d, d % 3, 1'b1, sl[d]);
    pulse(2, 0, 1'b0, 8'h00);
    rchk("sync_cfg", OFS_SYNC_CFG, 8'h20);
    wr(OFS_PORT_SYNC, 8'hFF);
    rchk("port_sync", OFS_PORT_SYNC, 8'h01);
    check("port_sync_pin", {7'h00, ssel}, 8'h01);
    wr(OFS_THR2, 8'h5A);
    rchk("thr2", OFS_THR2, 8'h5A);
    wr(OFS_THR2, 8'h00);
    wr(OFS_THR0, 8'h03);
    wr(OFS_LANE_EN, 8'h01);
    for (int p = 0; p < 3; p++) begin
      pat = 2'(p);
      wr(OFS_TEST_CTRL, {4'h0, pat, 2'h1});
      wr(OFS_TEST_CTRL, {4'h0, pat, 2'h2});
      flip_run(8'h03);
      rchk("cnt0", OFS_CNT0, 8'h03);
      rchk("cnt1", OFS_CNT1, 8'h00);
      rchk("cnt2", OFS_CNT2, 8'h00);
      rchk("pass", OFS_PASS, 8'hFE);
      wr(OFS_TEST_CTRL, {4'h1, pat, 2'h2});
      rchk("cnt_l1", OFS_CNT0, 8'h00);
      wr(OFS_TEST_CTRL, {4'h0, pat, 2'h0});
      flip_run(8'h01);
      rchk("cnt_stop", OFS_CNT0, 8'h03);
      wr(OFS_TEST_CTRL, {4'h0, pat, 2'h1});
      rchk("cnt_clr", OFS_CNT0, 8'h00);
      rchk("pass_clr", OFS_PASS, 8'hFF);
    end
    // unused code: the model keeps sending the short pattern, so any
    // checker that decodes code 3 as a real pattern would count errors
    pat = 2'h3;
    wr(OFS_TEST_CTRL, 8'hFE);
    rchk("ctrl", OFS_TEST_CTRL, 8'h7E);
    flip_run(8'h01);
    wr(OFS_TEST_CTRL, 8'h0E);
    rchk("cnt_pat3", OFS_CNT0, 8'h00);
    rchk("pass_pat3", OFS_PASS, 8'hFF);
    test_done();
  end
endmodule // sxp_lane_ctrl_tb
`default_nettype wire
